// ---- bench/output_driver_phase_config_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module output_driver_phase_config_tb;
   typedef struct packed {
      logic [7:0] adr;
      logic [7:0] wd;
      logic [7:0] rd;
      logic [1:0] term;
      logic [7:0] dd;
      logic [9:0] deg;
   } row_type;
   // each row: one write, the read back and the settings it should leave
   localparam row_type rows [8] = '{
      '{8'h58, 8'h00, 8'h00, 2'h0, 8'h00, 10'h000}, '{8'h58, 8'hFA, 8'h0A, 2'h0, 8'h00, 10'h258},
      '{8'h58, 8'h0B, 8'h0A, 2'h0, 8'h00, 10'h258}, '{8'h54, 8'h10, 8'h10, 2'h1, 8'h00, 10'h258},
      '{8'h54, 8'h21, 8'h21, 2'h2, 8'hFF, 10'h258}, '{8'h54, 8'hFF, 8'h31, 2'h2, 8'hFF, 10'h258},
      '{8'h58, 8'h05, 8'h05, 2'h2, 8'hFF, 10'h12C}, '{8'h54, 8'h00, 8'h00, 2'h0, 8'h00, 10'h12C}};
   logic                       clk_i;
   logic                       rst_i;
   logic                       cyc_i;
   logic                       stb_i;
   logic                       we_i;
   logic [7:0]                 adr_i;
   logic [3:0]                 sel_i;
   logic [31:0]                dat_i;
   logic [31:0]                dat_o;
   logic                       ack_o;
   out_drv_pkg::drive_out_type drive_o;
   logic [31:0]                rdat;
   int                         err_count = 0;
   int                         checks_done = 0;
   output_driver_phase_config i_output_driver_phase_config (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .drive_o(drive_o));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task end_sim;
      if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   // classic cycle; the edge-sampled iff sees ack before that edge's updates land
   task wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= s;
      @(posedge clk_i iff ack_o === 1'b1);
      rdat = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask : wb
   task rd_chk(input logic [7:0] a, input logic [7:0] e);
      wb(a, 1'b0, 32'h0000_0000, 4'hF);
      `CHK(rdat, {24'h00_0000, e})
   endtask : rd_chk
   task reset_defaults;
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      `CHK(drive_o.phase_code, 4'h3)
      `CHK(drive_o.phase_deg, 10'h0B4)
      `CHK({2'(drive_o.term), drive_o.drive_double}, 10'h000)
      rd_chk(out_drv_pkg::ADR_DRIVE_CFG, 8'h00);
      rd_chk(out_drv_pkg::ADR_PHASE_SEL, 8'h03);
   endtask : reset_defaults
   // a hung handshake ends the run here
   initial begin
      #200000;
      err_count++;
      end_sim();
   end
   initial begin
      {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
      rst_i = 1'b1;
      reset_defaults();
      foreach (rows[k]) begin
         wb(rows[k].adr, 1'b1, {24'h00_0000, rows[k].wd}, 4'h1);
         rd_chk(rows[k].adr, rows[k].rd);
         `CHK(2'(drive_o.term), rows[k].term)
         `CHK(drive_o.drive_double, rows[k].dd)
         `CHK(drive_o.phase_deg, rows[k].deg)
      end
      // every legal phase code, 60 degrees a step
      for (int c = 0; c <= 10; c++) begin
         wb(out_drv_pkg::ADR_PHASE_SEL, 1'b1, 32'(c), 4'h1);
         @(negedge clk_i);
         `CHK(drive_o.phase_deg, 10'(c * 60))
         `CHK(drive_o.phase_code, 4'(c))
      end
      // lane 0 not enabled: write must be dropped
      wb(out_drv_pkg::ADR_PHASE_SEL, 1'b1, 32'h0000_0007, 4'hE);
      rd_chk(out_drv_pkg::ADR_PHASE_SEL, 8'h0A);
      wb(8'h60, 1'b1, 32'hFFFF_FFFF, 4'hF);
      rd_chk(8'h60, 8'h00);
      // bit 0 lands only in the addressed channel, shared bits everywhere
      wb(out_drv_pkg::ADR_CHAN_SEL, 1'b1, 32'h0000_0004, 4'h1);
      wb(out_drv_pkg::ADR_DRIVE_CFG, 1'b1, 32'h0000_0011, 4'h1);
      rd_chk(out_drv_pkg::ADR_DRIVE_CFG, 8'h11);
      `CHK(drive_o.drive_double, 8'h04)
      `CHK(2'(drive_o.term), 2'h1)
      reset_defaults();
      end_sim();
   end
endmodule : output_driver_phase_config_tb
`default_nettype wire

// ---- design/out_drv_pkg.sv ----
package out_drv_pkg;
   localparam int          CHAN_COUNT      = 8;
   localparam int          ADR_W           = 8;
   // register indices; the bus byte address is four times the index
   localparam logic [7:0]  IDX_CHAN_SEL    = 8'h05;
   localparam logic [7:0]  IDX_DRIVE_CFG   = 8'h15;
   localparam logic [7:0]  IDX_PHASE_SEL   = 8'h16;
   localparam logic [7:0]  ADR_CHAN_SEL    = 8'h14;
   localparam logic [7:0]  ADR_DRIVE_CFG   = 8'h54;
   localparam logic [7:0]  ADR_PHASE_SEL   = 8'h58;
   // field layout of the drive and phase registers
   localparam int          TERM_LSB        = 4;
   localparam int          TERM_MSB        = 5;
   localparam int          DRIVE2X_BIT     = 0;
   localparam int          PHASE_MSB       = 3;
   // reset values
   localparam logic [7:0]  RST_DRIVE_CFG   = 8'h00;
   localparam logic [7:0]  RST_PHASE_SEL   = 8'h03;
   localparam logic [7:0]  RST_CHAN_SEL    = 8'hFF;
   localparam logic [3:0]  PHASE_MAX       = 4'hA;
   localparam logic [9:0]  PHASE_STEP_DEG  = 10'h03C;
   localparam logic [31:0] RD_ZERO         = 32'h0000_0000;

   typedef enum logic [1:0] {
      TERM_NONE  = 2'h0,
      TERM_200   = 2'h1,
      TERM_100   = 2'h2
   } term_type;

   // settings handed to the output stage
   typedef struct packed {
      term_type                term;
      logic [CHAN_COUNT-1:0]   drive_double;
      logic [3:0]              phase_code;
      logic [9:0]              phase_deg;
   } drive_out_type;
endpackage : out_drv_pkg

// ---- design/output_driver_phase_config.sv ----
// Operation
// - the clock phase field takes codes 0000 through 1010 and picks the divider phase for the output clock.
// - each code step delays the output clock a further 60 degrees after the data edge, up to 600.
// - after reset the phase register holds 0x03, i.e. 180 degrees.
// - changing the phase moves only the emitted output clock, never the internal data latching.
// - drive register bits 5..4 are shared by all channels while bit 0 is kept per addressed channel.
// - the two-bit termination field gives none for 00, 200 ohm for 01 and 100 ohm for 10 and 11.
// - drive bit 0 at 1 doubles data_clock_out and frame_clock_out drive, at 0 normal drive.
`timescale 1ns/1ps
`default_nettype none
module output_driver_phase_config (
   input  wire logic                                 clk_i,
   input  wire logic                                 rst_i,
   input  wire logic                                 cyc_i,
   input  wire logic                                 stb_i,
   input  wire logic                                 we_i,
   input  wire logic [out_drv_pkg::ADR_W-1:0]        adr_i,
   input  wire logic [3:0]                           sel_i,
   input  wire logic [31:0]                          dat_i,
   output logic [31:0]                               dat_o,
   output logic                                      ack_o,
   output out_drv_pkg::drive_out_type                drive_o
);
   localparam int NCH = out_drv_pkg::CHAN_COUNT;

   logic [1:0]     term_field;
   logic [NCH-1:0] drive_double;
   logic [NCH-1:0] chan_sel;
   logic [3:0]     phase_code;
   logic           req;
   logic           wr_lane0;
   logic           drive_bit_rd;

   // single-cycle answer: one ack per request, dropped the cycle after
   assign req      = cyc_i && stb_i && !ack_o;
   assign wr_lane0 = req && we_i && sel_i[0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= req;
      end
   end

   // channel address mask: which channels a write of the local bit reaches
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chan_sel <= out_drv_pkg::RST_CHAN_SEL;
      end else if (wr_lane0 && adr_i == out_drv_pkg::ADR_CHAN_SEL) begin
         chan_sel <= dat_i[NCH-1:0];
      end
   end

   // shared termination field; other upper bits are not stored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         term_field <= out_drv_pkg::RST_DRIVE_CFG[out_drv_pkg::TERM_MSB:out_drv_pkg::TERM_LSB];
      end else if (wr_lane0 && adr_i == out_drv_pkg::ADR_DRIVE_CFG) begin
         term_field <= dat_i[out_drv_pkg::TERM_MSB:out_drv_pkg::TERM_LSB];
      end
   end

   // local double-drive bit, one per channel, written only where addressed
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drive_double <= '0;
      end else if (wr_lane0 && adr_i == out_drv_pkg::ADR_DRIVE_CFG) begin
         for (int i = 0; i < NCH; i++) begin
            if (chan_sel[i]) begin
               drive_double[i] <= dat_i[out_drv_pkg::DRIVE2X_BIT];
            end
         end
      end
   end

   // phase code; out-of-range codes are dropped so the divider never
   // sees a phase it does not have
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_code <= out_drv_pkg::RST_PHASE_SEL[3:0];
      end else if (wr_lane0 && adr_i == out_drv_pkg::ADR_PHASE_SEL
                   && dat_i[3:0] <= out_drv_pkg::PHASE_MAX) begin
         phase_code <= dat_i[out_drv_pkg::PHASE_MSB:0];
      end
   end

   // readback of the local bit comes from the lowest addressed channel
   always_comb begin
      drive_bit_rd = 1'b0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (chan_sel[i]) begin
            drive_bit_rd = drive_double[i];
         end
      end
   end

   // read data; unmapped addresses answer with zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= out_drv_pkg::RD_ZERO;
      end else if (req && !we_i) begin
         if (adr_i == out_drv_pkg::ADR_DRIVE_CFG) begin
            dat_o <= {26'h0, term_field, 3'h0, drive_bit_rd};
         end else if (adr_i == out_drv_pkg::ADR_PHASE_SEL) begin
            dat_o <= {28'h0, phase_code};
         end else if (adr_i == out_drv_pkg::ADR_CHAN_SEL) begin
            dat_o <= {24'h0, chan_sel};
         end else begin
            dat_o <= out_drv_pkg::RD_ZERO;
         end
      end
   end

   // settings to the output stage; the phase only steers the clock
   // serializer, the data latch timing has no input from here
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drive_o.term         <= out_drv_pkg::TERM_NONE;
         drive_o.drive_double <= '0;
         drive_o.phase_code   <= out_drv_pkg::RST_PHASE_SEL[3:0];
         drive_o.phase_deg    <= 10'(out_drv_pkg::RST_PHASE_SEL[3:0]
                                     * out_drv_pkg::PHASE_STEP_DEG);
      end else begin
         case (term_field)
            2'h0:    drive_o.term <= out_drv_pkg::TERM_NONE;
            2'h1:    drive_o.term <= out_drv_pkg::TERM_200;
            default: drive_o.term <= out_drv_pkg::TERM_100;
         endcase
         drive_o.drive_double <= drive_double;
         drive_o.phase_code   <= phase_code;
         drive_o.phase_deg    <= 10'(phase_code * out_drv_pkg::PHASE_STEP_DEG);
      end
   end

   // checks
   a_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o) else $error("ack held two cycles");
   a_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o) |=> ack_o) else $error("request not answered");
   a_phase_in_range: assert property (@(posedge clk_i) disable iff (rst_i)
      drive_o.phase_code <= out_drv_pkg::PHASE_MAX) else $error("phase code out of range");
   a_phase_degree_map: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 drive_o.phase_deg == 10'($past(phase_code) * out_drv_pkg::PHASE_STEP_DEG))
      else $error("phase degrees wrong");
   a_phase_reset_val: assert property (@(posedge clk_i)
      $past(rst_i) |-> phase_code == 4'h3 && drive_o.phase_deg == 10'd180)
      else $error("phase reset value wrong");
   a_phase_bad_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_lane0 && adr_i == out_drv_pkg::ADR_PHASE_SEL && dat_i[3:0] > 4'hA)
      |=> $stable(phase_code)) else $error("bad phase code accepted");
   a_phase_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_lane0 && adr_i == out_drv_pkg::ADR_PHASE_SEL && dat_i[3:0] <= 4'hA)
      |=> ##1 drive_o.phase_code == $past(dat_i[3:0], 2)) else $error("phase not applied");
   a_term_decode: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 (drive_o.term == out_drv_pkg::TERM_100) == $past(term_field[1]))
      else $error("termination decode wrong");
   a_local_bit_masked: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_lane0 && adr_i == out_drv_pkg::ADR_DRIVE_CFG)
      |=> ((drive_double ^ $past(drive_double)) & ~$past(chan_sel)) == '0)
      else $error("unaddressed channel changed");
   a_drive_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 drive_o.drive_double == $past(drive_double)) else $error("drive not applied");
   a_unused_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !we_i && adr_i == out_drv_pkg::ADR_PHASE_SEL)
      |=> dat_o[31:4] == 28'h0) else $error("unused phase bits not zero");

   // reference copies rebuilt from the bus pins alone, so that the checks
   // below judge the storage against something it does not drive itself
   logic [3:0]     ref_phase;
   logic [1:0]     ref_term;
   logic [NCH-1:0] ref_double;
   logic [NCH-1:0] ref_mask;
   logic           ref_ack;

   // reference handshake: one answer per taken request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_ack <= 1'b0;
      end else begin
         ref_ack <= cyc_i && stb_i && !ref_ack;
      end
   end

   // reference phase code; codes above the last divider phase are dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_phase <= out_drv_pkg::RST_PHASE_SEL[3:0];
      end else if (cyc_i && stb_i && !ref_ack && we_i && sel_i[0]
                   && adr_i == out_drv_pkg::ADR_PHASE_SEL && dat_i[3:0] < 4'hB) begin
         ref_phase <= dat_i[3:0];
      end
   end

   // reference channel mask
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_mask <= out_drv_pkg::RST_CHAN_SEL;
      end else if (cyc_i && stb_i && !ref_ack && we_i && sel_i[0]
                   && adr_i == out_drv_pkg::ADR_CHAN_SEL) begin
         ref_mask <= dat_i[NCH-1:0];
      end
   end

   // reference termination field, shared by every channel
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_term <= 2'h0;
      end else if (cyc_i && stb_i && !ref_ack && we_i && sel_i[0]
                   && adr_i == out_drv_pkg::ADR_DRIVE_CFG) begin
         ref_term <= dat_i[5:4];
      end
   end

   // reference double-drive bits, written only in masked channels
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_double <= '0;
      end else if (cyc_i && stb_i && !ref_ack && we_i && sel_i[0]
                   && adr_i == out_drv_pkg::ADR_DRIVE_CFG) begin
         for (int i = 0; i < NCH; i++) begin
            if (ref_mask[i]) begin
               ref_double[i] <= dat_i[0];
            end
         end
      end
   end

   // handshake against the reference
   a_ack_matches_ref: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o == ref_ack) else $error("ack differs from reference");
   a_no_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      !(cyc_i && stb_i) |=> !ack_o) else $error("ack without request");

   // stored fields against the reference
   a_phase_ref_match: assert property (@(posedge clk_i) disable iff (rst_i)
      phase_code == ref_phase) else $error("phase code differs from reference");
   a_term_ref_match: assert property (@(posedge clk_i) disable iff (rst_i)
      term_field == ref_term) else $error("termination differs from reference");
   a_double_ref_match: assert property (@(posedge clk_i) disable iff (rst_i)
      drive_double == ref_double) else $error("local bits differ from reference");
   a_mask_ref_match: assert property (@(posedge clk_i) disable iff (rst_i)
      chan_sel == ref_mask) else $error("channel mask differs from reference");

   // output stage settings, one cycle behind the stored fields
   a_term_full_decode: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 drive_o.term == ($past(ref_term) == 2'h0 ? out_drv_pkg::TERM_NONE :
                           $past(ref_term) == 2'h1 ? out_drv_pkg::TERM_200 :
                           out_drv_pkg::TERM_100))
      else $error("termination decode differs");
   a_deg_step_240: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 ($past(ref_phase) == 4'h4) |-> drive_o.phase_deg == 10'h0F0)
      else $error("code 4 not 240 degrees");
   a_deg_max_600: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 ($past(ref_phase) == 4'hA) |-> drive_o.phase_deg == 10'h258)
      else $error("code 10 not 600 degrees");
   a_phase_code_out: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 drive_o.phase_code == $past(ref_phase)) else $error("phase output stale");
   a_double_out_ref: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 drive_o.drive_double == $past(ref_double)) else $error("drive output stale");

   // reset leaves every output at its default
   a_reset_outputs: assert property (@(posedge clk_i)
      rst_i |=> !ack_o && dat_o == out_drv_pkg::RD_ZERO
                && drive_o.phase_code == 4'h3 && drive_o.term == out_drv_pkg::TERM_NONE
                && drive_o.drive_double == '0)
      else $error("outputs not at reset defaults");

   // read data contents
   a_read_drive_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !we_i && adr_i == out_drv_pkg::ADR_DRIVE_CFG)
      |=> dat_o[31:6] == 26'h0 && dat_o[3:1] == 3'h0) else $error("unused drive bits set");
   a_read_drive_term: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !we_i && adr_i == out_drv_pkg::ADR_DRIVE_CFG)
      |=> dat_o[5:4] == $past(ref_term)) else $error("termination read wrong");
   a_mask_empty_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !we_i && adr_i == out_drv_pkg::ADR_DRIVE_CFG && chan_sel == '0)
      |=> !dat_o[0]) else $error("empty mask reads a local bit");
   a_read_phase_value: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !we_i && adr_i == out_drv_pkg::ADR_PHASE_SEL)
      |=> dat_o[3:0] == $past(ref_phase)) else $error("phase read wrong");
   a_read_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !we_i && adr_i != out_drv_pkg::ADR_DRIVE_CFG
       && adr_i != out_drv_pkg::ADR_PHASE_SEL && adr_i != out_drv_pkg::ADR_CHAN_SEL)
      |=> dat_o == out_drv_pkg::RD_ZERO) else $error("unmapped read not zero");
   a_dat_holds: assert property (@(posedge clk_i) disable iff (rst_i)
      !(req && !we_i) |=> $stable(dat_o)) else $error("read data moved");

   // writes that must leave state alone
   a_data_path_free: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_lane0 && adr_i == out_drv_pkg::ADR_PHASE_SEL)
      |=> $stable(drive_double) && $stable(term_field)) else $error("phase write leaked");
   a_lane_off_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && we_i && !sel_i[0])
      |=> $stable(phase_code) && $stable(term_field) && $stable(drive_double))
      else $error("write without lane 0 landed");

   c_phase_max: cover property (@(posedge clk_i) drive_o.phase_code == 4'hA);
   c_term_200: cover property (@(posedge clk_i) drive_o.term == out_drv_pkg::TERM_200);
   c_one_chan_double: cover property (@(posedge clk_i)
      drive_double != '0 && drive_double != '1);
   c_bad_phase_write: cover property (@(posedge clk_i)
      wr_lane0 && adr_i == out_drv_pkg::ADR_PHASE_SEL && dat_i[3:0] > 4'hA);
   c_empty_mask_read: cover property (@(posedge clk_i)
      req && !we_i && adr_i == out_drv_pkg::ADR_DRIVE_CFG && chan_sel == '0);
endmodule : output_driver_phase_config
`default_nettype wire
